//--- src/ldf_ctrl.sv
// boost gate drive, string protection and dimming registers of the LED driver
`timescale 1ns/10ps
`default_nettype none
module ldf_ctrl
  import ldf_pkg::*;
#(
  parameter int DETECT_CYCLES = ldf_pkg::DETECT_CYC,
  parameter int OSC_PERIOD = ldf_pkg::OSC_PERIOD_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial register pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // chip enable qualified by supply good
  input wire logic enableIn,
  // boost power stage
  input wire logic currentTrip,
  input wire logic overvoltage_sense,
  input wire logic boost_sync_in,
  output logic gate_drive_out,
  // string sinks
  input wire logic short_protect_cfg,
  input wire logic [ldf_pkg::NSTR-1:0] sinkHigh,
  input wire logic [ldf_pkg::NSTR-1:0] sinkLow,
  input wire logic [ldf_pkg::NSTR-1:0] sinkPwmOn,
  output logic [ldf_pkg::NSTR-1:0] sinkEnable,
  // dimming control
  output logic [7:0] analogDimLevel,
  output logic dimDirect,
  output logic dimIndirect,
  output logic dimRegister,
  output logic [5:0] ctlUpper,
  // fault
  output logic fault_flag_n
);
  import ldf_pkg::*;

  localparam logic [7:0] OSC_LAST = 8'(OSC_PERIOD - 1);
  localparam logic [7:0] SYNC_MIN = 8'(OSC_PERIOD * (100 - SYNC_TOL_PCT) / 100);
  localparam logic [7:0] SYNC_MAX = 8'(OSC_PERIOD * (100 + SYNC_TOL_PCT) / 100);
  localparam logic [15:0] DET_LAST = 16'(DETECT_CYCLES - 1);
  localparam logic [8:0] SHORT_LAST = 9'(SHORT_CYC - 1);

  typedef struct packed {
    logic [IN_W-1:0] sy1;
    logic [IN_W-1:0] sy2;
    logic [IN_W-1:0] sy3;
    logic [IN_W-1:0] filt;
    ldf_phase_t phase;
    logic [15:0] detCnt;
    logic [7:0] oscCnt;
    logic [7:0] syncCnt;
    logic syncPrev;
    logic syncLock;
    logic gate;
    logic [NSTR-1:0] unused;
    logic [NSTR-1:0] shortLat;
    logic [NSTR-1:0] openLat;
    logic [NSTR-1:0][8:0] shortCnt;
    logic [NSTR-1:0] sinkEn;
    logic faultN;
    logic [7:0] devCtl;
    logic [7:0] dimLevel;
    logic [2:0] modeDec;
  } ldf_ctrl_state_t;

  ldf_ctrl_state_t s;
  ldf_ctrl_state_t next_s;
  ldf_reg_if regBus();

  logic [IN_W-1:0] asyncIn;
  logic [IN_W-1:0] agree;
  logic running;
  logic ovFault;
  logic tripNow;
  logic shortOff;
  logic enNow;
  logic syncEdge;
  logic periodOk;
  logic cycleStart;
  logic [NSTR-1:0] high;
  logic [NSTR-1:0] low;
  logic [NSTR-1:0] live;

  // ==========================================================
  // register slave
  ldf_i2c_slave u_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .bus(regBus)
  );

  assign asyncIn = {sinkLow, sinkHigh, boost_sync_in, enableIn, short_protect_cfg,
                    overvoltage_sense, currentTrip};

  // ==========================================================
  // filtered views of the comparator and pin inputs
  always_comb begin
    agree = s.sy2 ~^ s.sy3;
    running = (s.phase == PH_RUN);
    ovFault = s.filt[IN_OV];
    tripNow = s.filt[IN_TRIP];
    shortOff = s.filt[IN_SHORTCFG];
    enNow = s.filt[IN_EN];
    high = s.filt[IN_HIGH +: NSTR];
    low = s.filt[IN_LOW +: NSTR];
    live = ~s.unused & ~s.shortLat & ~s.openLat;
    syncEdge = s.filt[IN_SYNC] & ~s.syncPrev;
    // an edge counts as sync only if the period since the last one is in tolerance
    periodOk = (s.syncCnt >= SYNC_MIN) && (s.syncCnt <= SYNC_MAX); // RULE3
    if (s.syncLock) begin
      // a missing sync edge still ends the cycle at the slow limit
      cycleStart = (syncEdge && periodOk) || (s.oscCnt >= SYNC_MAX); // RULE3
    end else begin
      cycleStart = (s.oscCnt >= OSC_LAST) || (syncEdge && periodOk); // RULE3
    end
  end

  // ==========================================================
  // core state
  always_comb begin
    next_s = s;
    next_s.sy1 = asyncIn;
    next_s.sy2 = s.sy1;
    next_s.sy3 = s.sy2;
    next_s.filt = (agree & s.sy3) | (~agree & s.filt);
    next_s.syncPrev = s.filt[IN_SYNC];

    // sync tracking
    if (syncEdge) begin
      next_s.syncLock = periodOk;
      next_s.syncCnt = 8'h00;
    end else if (s.syncCnt != 8'hFF) begin
      next_s.syncCnt = s.syncCnt + 8'h01;
    end
    if (s.syncCnt > SYNC_MAX) begin
      next_s.syncLock = 1'b0;
    end

    // oscillator
    next_s.oscCnt = cycleStart ? 8'h00 : s.oscCnt + 8'h01;

    // start-up sequencing; losing enable clears every latch
    case (s.phase)
      PH_OFF: begin
        next_s.detCnt = 16'h0000;
        next_s.unused = '0;
        next_s.shortLat = '0; // RULE8
        next_s.openLat = '0; // RULE12
        if (enNow) begin
          next_s.phase = PH_DETECT;
        end
      end
      PH_DETECT: begin
        next_s.detCnt = s.detCnt + 16'h0001;
        if (!enNow) begin
          next_s.phase = PH_OFF;
        end else if (s.detCnt == DET_LAST) begin
          // grounded pins are parked as unused, no fault raised
          next_s.unused = low; // RULE6
          next_s.phase = PH_RUN;
        end
      end
      PH_RUN: begin
        if (!enNow) begin
          next_s.phase = PH_OFF;
        end
      end
      default: begin
        next_s.phase = PH_OFF;
      end
    endcase

    // gate-drive latch: set wins at cycle start, current trip ends the on-time
    if (!running || ovFault) begin
      next_s.gate = 1'b0; // RULE4 RULE5
    end else if (cycleStart) begin
      next_s.gate = 1'b1; // RULE1
    end else if (tripNow) begin
      next_s.gate = 1'b0; // RULE2
    end

    // per-string protection
    for (int i = 0; i < NSTR; i++) begin
      if (running && live[i] && !shortOff && sinkPwmOn[i] && high[i]) begin // RULE9
        // on-time only; a short pwm pulse restarts the count
        if (s.shortCnt[i] == SHORT_LAST) begin
          next_s.shortLat[i] = 1'b1; // RULE7 RULE10
        end else begin
          next_s.shortCnt[i] = s.shortCnt[i] + 9'h001; // RULE10
        end
      end else begin
        next_s.shortCnt[i] = 9'h000; // RULE10
      end
      if (running && live[i] && sinkPwmOn[i] && low[i] && ovFault) begin
        next_s.openLat[i] = 1'b1; // RULE11
      end
    end
    next_s.sinkEn = (running ? 4'hF : 4'h0) & ~next_s.unused & ~next_s.shortLat & ~next_s.openLat; // RULE8 RULE11

    // fault flag: over-voltage live, the others latched
    next_s.faultN = ~(ovFault | (|next_s.shortLat) | (|next_s.openLat)); // RULE16 RULE4 RULE5 RULE12

    // register writes
    if (regBus.wrStb) begin
      case (regBus.wrAddr)
        ADDR_DEV_CTL: next_s.devCtl = regBus.wrData; // RULE14
        ADDR_DIM_LEVEL: next_s.dimLevel = regBus.wrData; // RULE13
        default: begin
        end
      endcase
    end
    next_s.modeDec = ldf_mode_dec(next_s.devCtl[1:0]); // RULE14 RULE15

    if (rst) begin
      next_s = '0;
      next_s.faultN = 1'b1;
      next_s.devCtl = RST_DEV_CTL; // RULE15
      next_s.dimLevel = RST_DIM_LEVEL;
      next_s.modeDec = ldf_mode_dec(RST_DEV_CTL[1:0]);
      next_s.phase = PH_OFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  // ==========================================================
  // register read-back, unmapped reads return zero
  always_comb begin
    case (regBus.rdAddr)
      ADDR_DEV_CTL: regBus.rdData = s.devCtl;
      ADDR_DIM_LEVEL: regBus.rdData = s.dimLevel;
      ADDR_FAULT_STAT: regBus.rdData = {s.openLat, s.shortLat};
      ADDR_LINK_STAT: regBus.rdData = {s.unused, 2'h0, ovFault, s.syncLock};
      default: regBus.rdData = 8'h00;
    endcase
  end

  // ==========================================================
  // outputs
  assign gate_drive_out = s.gate;
  assign sinkEnable = s.sinkEn;
  assign analogDimLevel = s.dimLevel; // RULE13
  assign dimDirect = s.modeDec[0];
  assign dimIndirect = s.modeDec[1];
  assign dimRegister = s.modeDec[2];
  assign ctlUpper = s.devCtl[7:2];
  assign fault_flag_n = s.faultN;
endmodule
`default_nettype wire

//--- src/ldf_i2c_slave.sv
// two-wire serial register slave with auto-incrementing register pointer
`timescale 1ns/10ps
`default_nettype none
module ldf_i2c_slave
  import ldf_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // register path
  ldf_reg_if.slave bus
);
  typedef struct packed {
    logic [2:0] sclSy;
    logic [2:0] sdaSy;
    logic sclF;
    logic sdaF;
    ldf_i2c_st_t st;
    logic [3:0] bitCnt;
    logic [7:0] sh;
    logic [7:0] regPtr;
    logic rw;
    logic drvLow;
    logic wrStb;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
  } ldf_i2c_state_t;

  ldf_i2c_state_t s;
  ldf_i2c_state_t next_s;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic sclNew;
  logic sdaNew;

  // ==========================================================
  // pin filtering and bus conditions
  always_comb begin
    sclNew = (s.sclSy[1] == s.sclSy[2]) ? s.sclSy[2] : s.sclF;
    sdaNew = (s.sdaSy[1] == s.sdaSy[2]) ? s.sdaSy[2] : s.sdaF;
    sclRise = sclNew & ~s.sclF;
    sclFall = ~sclNew & s.sclF;
    startCond = s.sclF & sclNew & s.sdaF & ~sdaNew;
    stopCond = s.sclF & sclNew & ~s.sdaF & sdaNew;
  end

  // ==========================================================
  // protocol engine
  always_comb begin
    next_s = s;
    next_s.sclSy = {s.sclSy[1:0], sclIn};
    next_s.sdaSy = {s.sdaSy[1:0], sdaIn};
    next_s.sclF = sclNew;
    next_s.sdaF = sdaNew;
    next_s.wrStb = 1'b0;
    if (startCond) begin
      next_s.st = I2_ADDR;
      next_s.bitCnt = 4'h0;
      next_s.drvLow = 1'b0;
    end else if (stopCond) begin
      next_s.st = I2_IDLE;
      next_s.drvLow = 1'b0;
    end else if (sclRise) begin
      case (s.st)
        I2_ADDR, I2_REG, I2_WDATA, I2_RDATA: begin
          next_s.sh = (s.st == I2_RDATA) ? {s.sh[6:0], 1'b0} : {s.sh[6:0], sdaNew};
          next_s.bitCnt = s.bitCnt + 4'h1;
        end
        I2_RACK: begin
          // a not-acknowledge ends the read burst
          if (sdaNew) begin
            next_s.st = I2_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      case (s.st)
        I2_ADDR: begin
          if (s.bitCnt == 4'h8) begin
            if (s.sh[7:1] == I2C_DEV_ADDR) begin
              next_s.rw = s.sh[0];
              next_s.drvLow = 1'b1;
              next_s.st = I2_ACKA;
            end else begin
              next_s.st = I2_IDLE;
            end
          end
        end
        I2_REG, I2_WDATA: begin
          if (s.bitCnt == 4'h8) begin
            if (s.st == I2_REG) begin
              next_s.regPtr = s.sh;
            end else begin
              next_s.wrStb = 1'b1;
              next_s.wrAddr = s.regPtr;
              next_s.wrData = s.sh;
              next_s.regPtr = s.regPtr + 8'h01;
            end
            next_s.drvLow = 1'b1;
            next_s.st = I2_ACKW;
          end
        end
        I2_ACKW: begin
          next_s.drvLow = 1'b0;
          next_s.bitCnt = 4'h0;
          next_s.st = I2_WDATA;
        end
        I2_ACKA, I2_RACK: begin
          next_s.bitCnt = 4'h0;
          if (s.st == I2_ACKA && !s.rw) begin
            next_s.drvLow = 1'b0;
            next_s.st = I2_REG;
          end else begin
            next_s.sh = bus.rdData;
            next_s.drvLow = ~bus.rdData[7];
            next_s.regPtr = s.regPtr + 8'h01;
            next_s.st = I2_RDATA;
          end
        end
        I2_RDATA: begin
          if (s.bitCnt == 4'h8) begin
            next_s.drvLow = 1'b0;
            next_s.st = I2_RACK;
          end else begin
            next_s.drvLow = ~s.sh[7];
          end
        end
        default: begin
        end
      endcase
    end
    if (rst) begin
      next_s = '0;
      next_s.sclSy = 3'h7;
      next_s.sdaSy = 3'h7;
      next_s.sclF = 1'b1;
      next_s.sdaF = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  // open drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe = s.drvLow;
  assign bus.wrStb = s.wrStb;
  assign bus.wrAddr = s.wrAddr;
  assign bus.wrData = s.wrData;
  assign bus.rdAddr = s.regPtr;
endmodule
`default_nettype wire

//--- src/ldf_pkg.sv
// constants, types and decode helpers of the LED driver fault and dimming control
//
// Function
// RULE1: every oscillator cycle start sets the gate-drive latch, switching the boost FET on.
// RULE2: current-sense trip resets the gate-drive latch, FET off for the cycle.
// RULE3: gate drive rises with external sync edges only within +/-10 % of free-run.
// RULE4: over-voltage sense high stops boost switching and pulls the fault flag low.
// RULE5: over-voltage is not latched; switching and fault flag recover when it clears.
// RULE6: grounded string pins at start-up are disabled silently; other strings run.
// RULE7: a string sink above the short trip level is latched off and flags fault.
// RULE8: short latch clears only by enable or supply cycling; healthy strings keep running.
// RULE9: short-protect configuration high disables short detection on every string.
// RULE10: short must persist 10 us of sink on-time; shorter pulses never latch.
// RULE11: open string with output at over-voltage clamp is latched off and flags fault.
// RULE12: open latch and its fault clear only by enable or supply cycling.
// RULE13: 8-bit analog dimming register at 0x02 sets string current in 256 steps.
// RULE14: three PWM dimming modes chosen by device control bits [1:0] at 0x01.
// RULE15: mode 00 direct, 01 indirect (reset default), 11 register-controlled.
// RULE16: fault flag is OR of over-voltage, short and open faults, latched ones held.
package ldf_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 40;
  localparam int SHORT_DET_NS = 10000;
  localparam int SHORT_CYC = (SHORT_DET_NS * CLK_MHZ + 999) / 1000;
  localparam int DETECT_US = 1000;
  localparam int DETECT_CYC = DETECT_US * CLK_MHZ;
  localparam int OSC_PERIOD_DEF = 40;
  localparam int SYNC_TOL_PCT = 10;
  localparam int NSTR = 4;
  // ==========================================================
  // register map
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2C;
  localparam logic [7:0] ADDR_DEV_CTL = 8'h01;
  localparam logic [7:0] ADDR_DIM_LEVEL = 8'h02;
  localparam logic [7:0] ADDR_FAULT_STAT = 8'h08;
  localparam logic [7:0] ADDR_LINK_STAT = 8'h09;
  localparam logic [7:0] RST_DEV_CTL = 8'h01;
  localparam logic [7:0] RST_DIM_LEVEL = 8'hFF;
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_INDIRECT = 2'h1;
  localparam logic [1:0] MODE_REGISTER = 2'h3;
  // ==========================================================
  // positions inside the vector of asynchronous inputs
  localparam int IN_TRIP = 0;
  localparam int IN_OV = 1;
  localparam int IN_SHORTCFG = 2;
  localparam int IN_EN = 3;
  localparam int IN_SYNC = 4;
  localparam int IN_HIGH = 5;
  localparam int IN_LOW = 9;
  localparam int IN_W = 13;
  // ==========================================================
  // states
  typedef enum logic [1:0] {PH_OFF = 2'b00, PH_DETECT = 2'b01, PH_RUN = 2'b10} ldf_phase_t;
  typedef enum logic [2:0] {
    I2_IDLE = 3'b000, I2_ADDR = 3'b001, I2_ACKA = 3'b010, I2_REG = 3'b011,
    I2_WDATA = 3'b100, I2_ACKW = 3'b101, I2_RDATA = 3'b110, I2_RACK = 3'b111
  } ldf_i2c_st_t;
  // ==========================================================
  // mode decode: {register, indirect, direct}; reserved code 10 acts as indirect
  function automatic logic [2:0] ldf_mode_dec(input logic [1:0] m);
    case (m)
      MODE_DIRECT: ldf_mode_dec = 3'h1;
      MODE_REGISTER: ldf_mode_dec = 3'h4;
      default: ldf_mode_dec = 3'h2;
    endcase
  endfunction
endpackage

//--- src/ldf_reg_if.sv
// register access path between the serial slave and the control core
`timescale 1ns/10ps
`default_nettype none
interface ldf_reg_if;
  logic wrStb;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  modport slave (output wrStb, output wrAddr, output wrData, output rdAddr, input rdData);
  modport regs (input wrStb, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface
`default_nettype wire

//--- tb/ldf_ctrl_sva.sv
// assertion checker bound to the LED driver control top
`timescale 1ns/10ps
`default_nettype none
module ldf_ctrl_sva #(
  parameter int DETECT_CYCLES = 20,
  parameter int OSC_PERIOD = 40
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // power stage and string pins
  input wire logic enableIn,
  input wire logic currentTrip,
  input wire logic overvoltage_sense,
  input wire logic short_protect_cfg,
  input wire logic [3:0] sinkHigh,
  input wire logic [3:0] sinkPwmOn,
  input wire logic gate_drive_out,
  input wire logic [3:0] sinkEnable,
  // dimming and fault outputs
  input wire logic [7:0] analogDimLevel,
  input wire logic dimDirect,
  input wire logic dimIndirect,
  input wire logic dimRegister,
  input wire logic fault_flag_n
);
  localparam int GATE_GAP = OSC_PERIOD + 6;
  logic [9:0] hiRun [4];
  logic [3:0] ovRun;
  // ==========================================================
  // run lengths at the pins; they lead the filtered view by a few edges
  always_ff @(posedge ref_clk) begin
    ovRun <= (rst || overvoltage_sense) ? 4'h0 : (ovRun == 4'hF ? ovRun : ovRun + 4'h1);
    for (int i = 0; i < 4; i++) begin
      hiRun[i] <= (rst || !(sinkHigh[i] && sinkPwmOn[i] && !short_protect_cfg)) ? 10'h0 :
        (hiRun[i] == 10'h3FF ? hiRun[i] : hiRun[i] + 10'h1);
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // properties
  AST_OVERVOLT_STOP: assert property ((enableIn && overvoltage_sense) [*7] |-> !gate_drive_out && !fault_flag_n)
    else $error("switching or flag not stopped by over-voltage");
  AST_EN_CLEAR: assert property ((!enableIn && !overvoltage_sense) [*8] |-> !gate_drive_out && sinkEnable == 4'h0 && fault_flag_n)
    else $error("disable did not clear drive and latches");
  AST_LATCH_FLAG: assert property (enableIn && $past(enableIn, 8) && ($past(sinkEnable) & ~sinkEnable) != 4'h0 |-> !fault_flag_n)
    else $error("string latched off without fault flag");
  AST_TRIP_OFF: assert property (currentTrip [*7] |-> !(gate_drive_out && $past(gate_drive_out)))
    else $error("gate stayed on through current trip");
  AST_GATE_RESTART: assert property ($fell(gate_drive_out) && ovRun == 4'hF && enableIn |-> ##[1:GATE_GAP] (gate_drive_out || overvoltage_sense || !enableIn))
    else $error("switching cycle did not restart");
  AST_RESET_DIM: assert property ($fell(rst) |-> analogDimLevel == 8'hFF && dimIndirect && !dimDirect && !dimRegister)
    else $error("dimming reset values wrong");
  AST_MODE_ONE: assert property ($onehot({dimDirect, dimIndirect, dimRegister}))
    else $error("mode decode not one-hot");
  for (genvar g = 0; g < 4; g++) begin : gShort
    AST_SHORT_TIME: assert property (enableIn && $past(enableIn, 8) && ovRun == 4'hF && $fell(sinkEnable[g]) |-> $past(hiRun[g], 5) >= 10'h186)
      else $error("string latched off without a long short");
  end
endmodule
bind ldf_ctrl ldf_ctrl_sva #(.DETECT_CYCLES(DETECT_CYCLES), .OSC_PERIOD(OSC_PERIOD)) ldf_ctrl_sva_inst (
  .ref_clk, .rst, .enableIn, .currentTrip, .overvoltage_sense, .short_protect_cfg, .sinkHigh, .sinkPwmOn,
  .gate_drive_out, .sinkEnable, .analogDimLevel, .dimDirect, .dimIndirect, .dimRegister, .fault_flag_n);
`default_nettype wire

//--- tb/ldf_power_model.sv
// behavioural boost power stage and LED strings facing the control block
`timescale 1ns/10ps
`default_nettype none
module ldf_power_model (
  // clock
  input wire logic ref_clk,
  // drive from the block
  input wire logic gate_drive_out,
  input wire logic [3:0] sinkEnable,
  // fault scenario set by the bench
  input wire logic [3:0] groundMask,
  input wire logic [3:0] openMask,
  input wire logic [3:0] shortMask,
  input wire logic ovForce,
  input wire logic [3:0] onTime,
  // sensed levels
  output logic currentTrip,
  output logic overvoltage_sense,
  output logic [3:0] sinkHigh,
  output logic [3:0] sinkLow
);
  logic [4:0] onCnt = 5'h0;
  logic [4:0] offCnt = 5'h0;
  logic [5:0] vRise = 6'h0;
  initial begin
    currentTrip = 1'b0;
    overvoltage_sense = 1'b0;
  end
  // trip outlasts the on-time, so the block must not rely on it falling quickly
  always @(posedge ref_clk) begin
    onCnt <= gate_drive_out ? (onCnt == 5'h1F ? onCnt : onCnt + 5'h1) : 5'h0;
    offCnt <= gate_drive_out ? 5'h0 : (offCnt == 5'h1F ? offCnt : offCnt + 5'h1);
    currentTrip <= gate_drive_out ? (currentTrip || onCnt >= {1'b0, onTime}) : (currentTrip && offCnt < 5'h0C);
    vRise <= |(openMask & sinkEnable) ? (vRise == 6'h3F ? vRise : vRise + 6'h1) : 6'h0;
    overvoltage_sense <= ovForce || vRise >= 6'h14;
  end
  assign sinkLow = groundMask | openMask;
  assign sinkHigh = shortMask;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench of the LED driver control top
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ldf_pkg::*;
  localparam int DET = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sclIn = 1'b1;
  logic sdaM = 1'b1;
  logic enableIn = 1'b0;
  logic boost_sync_in = 1'b0;
  logic short_protect_cfg = 1'b0;
  logic [3:0] sinkPwmOn = 4'hF;
  logic [3:0] groundMask = 4'h8;
  logic [3:0] openMask = 4'h0;
  logic [3:0] shortMask = 4'h0;
  logic ovForce = 1'b0;
  logic [3:0] onTime = 4'h6;
  logic syncOn = 1'b0;
  logic [31:0] seed = 32'h74325EAE;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int syncCnt = 0;
  logic sdaOut, sdaOe, currentTrip, overvoltage_sense, gate_drive_out;
  logic dimDirect, dimIndirect, dimRegister, fault_flag_n;
  logic [3:0] sinkHigh, sinkLow, sinkEnable;
  logic [7:0] analogDimLevel, rd;
  logic [5:0] ctlUpper;
  wire logic sdaIn = sdaM && !(sdaOe && !sdaOut);
  ldf_ctrl #(.DETECT_CYCLES(DET), .OSC_PERIOD(40)) ldf_ctrl_inst (.ref_clk, .rst, .sclIn, .sdaIn, .sdaOut,
    .sdaOe, .enableIn, .currentTrip, .overvoltage_sense, .boost_sync_in, .gate_drive_out, .short_protect_cfg,
    .sinkHigh, .sinkLow, .sinkPwmOn, .sinkEnable, .analogDimLevel, .dimDirect, .dimIndirect, .dimRegister,
    .ctlUpper, .fault_flag_n);
  ldf_power_model ldf_power_model_inst (.ref_clk, .gate_drive_out, .sinkEnable, .groundMask, .openMask,
    .shortMask, .ovForce, .onTime, .currentTrip, .overvoltage_sense, .sinkHigh, .sinkLow);
  always #12.5 ref_clk = ~ref_clk;
  // sync period 38 sits inside the lock window but off the free-run period
  always @(posedge ref_clk) begin
    syncCnt <= (syncCnt >= 37) ? 0 : syncCnt + 1;
    boost_sync_in <= #1 syncOn && syncCnt < 19;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] expMode(input logic [1:0] m);
    return m == 2'h0 ? 8'h01 : (m == 2'h3 ? 8'h04 : 8'h02);
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (exp !== got) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic sbit(input logic b, output logic r);
    wt(3);
    sdaM = b;
    wt(10);
    sclIn = 1'b1;
    wt(12);
    r = sdaIn;
    sclIn = 1'b0;
  endtask
  task automatic i2cStart();
    wt(6);
    sdaM = 1'b1;
    wt(6);
    sclIn = 1'b1;
    wt(12);
    sdaM = 1'b0;
    wt(12);
    sclIn = 1'b0;
  endtask
  task automatic i2cStop();
    wt(3);
    sdaM = 1'b0;
    wt(10);
    sclIn = 1'b1;
    wt(12);
    sdaM = 1'b1;
    wt(12);
  endtask
  task automatic wbyte(input logic [7:0] d, input logic ackExp);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(d[i], r);
    sbit(1'b1, r);
    chk("ack", {7'h0, ackExp}, {7'h0, r});
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    i2cStart();
    wbyte({I2C_DEV_ADDR, 1'b0}, 1'b0);
    wbyte(a, 1'b0);
    wbyte(d, 1'b0);
    i2cStop();
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    logic r;
    i2cStart();
    wbyte({I2C_DEV_ADDR, 1'b0}, 1'b0);
    wbyte(a, 1'b0);
    i2cStart();
    wbyte({I2C_DEV_ADDR, 1'b1}, 1'b0);
    for (int i = 7; i >= 0; i--) sbit(1'b1, d[i]);
    sbit(1'b1, r);
    i2cStop();
  endtask
  task automatic rises(input int n, output int k);
    logic p;
    k = 0;
    p = gate_drive_out;
    repeat (n) begin
      wt(1);
      if (gate_drive_out && !p) k++;
      p = gate_drive_out;
    end
  endtask
  task automatic state(input logic [3:0] s, input logic f);
    chk("strings", {4'h0, s}, {4'h0, sinkEnable});
    chk("fault flag", {7'h0, f}, {7'h0, fault_flag_n});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int k;
    logic [7:0] v;
    wt(2);
    rst = 1'b0;
    wt(4);
    chk("mode", 8'h02, {5'h0, dimRegister, dimIndirect, dimDirect});
    rreg(ADDR_DEV_CTL, rd);
    chk("ctl reset", 8'h01, rd);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'h00 : seed[7:0];
      wreg(ADDR_DIM_LEVEL, v);
      chk("dim level", v, analogDimLevel);
      rreg(ADDR_DIM_LEVEL, rd);
      chk("dim readback", v, rd);
    end
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      v = {seed[7:2], m[1:0]};
      wreg(ADDR_DEV_CTL, v);
      chk("mode", expMode(m[1:0]), {5'h0, dimRegister, dimIndirect, dimDirect});
      chk("ctl upper", {2'h0, v[7:2]}, {2'h0, ctlUpper});
    end
    wreg(8'h05, 8'h5A);
    rreg(8'h05, rd);
    chk("unmapped", 8'h00, rd);
    rreg(ADDR_DEV_CTL, rd);
    chk("ctl kept", v, rd);
    i2cStart();
    wbyte({I2C_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1);
    i2cStop();
    seed = lfsr(seed);
    onTime = 4'h3 + {1'b0, seed[2:0]};
    enableIn = 1'b1;
    wt(DET + 20);
    state(4'h7, 1'b1);
    rises(400, k);
    chk("gate cycles", 8'h0A, k[7:0]);
    ovForce = 1'b1;
    wt(8);
    rises(100, k);
    chk("gate in overvolt", 8'h00, k[7:0]);
    state(4'h7, 1'b0);
    ovForce = 1'b0;
    wt(10);
    state(4'h7, 1'b1);
    rises(80, k);
    chk("gate after overvolt", 8'h02, k[7:0]);
    shortMask = 4'h1;
    repeat (3) begin
      sinkPwmOn = 4'hF;
      wt(300);
      sinkPwmOn = 4'hE;
      wt(100);
    end
    state(4'h7, 1'b1);
    short_protect_cfg = 1'b1;
    wt(10);
    sinkPwmOn = 4'hF;
    wt(600);
    state(4'h7, 1'b1);
    short_protect_cfg = 1'b0;
    wt(450);
    state(4'h6, 1'b0);
    shortMask = 4'h0;
    wt(50);
    state(4'h6, 1'b0);
    rises(80, k);
    chk("gate with latch", 8'h02, k[7:0]);
    openMask = 4'h2;
    wt(100);
    state(4'h4, 1'b0);
    openMask = 4'h0;
    wt(50);
    state(4'h4, 1'b0);
    rreg(ADDR_FAULT_STAT, rd);
    chk("fault status", 8'h21, rd);
    enableIn = 1'b0;
    wt(20);
    state(4'h0, 1'b1);
    enableIn = 1'b1;
    wt(DET + 20);
    state(4'h7, 1'b1);
    syncOn = 1'b1;
    wt(200);
    repeat (6) begin
      @(posedge boost_sync_in);
      rises(12, k);
      chk("sync align", 8'h01, k[7:0]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
